/* rtl/uart_tx_regs.svh */
// Purpose: Register map and constants of the frame-format transmitter
// Assumes: APB, 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
`ifndef UART_TX_REGS_SVH
`define UART_TX_REGS_SVH
`define OFS_DATA_BUFFER 12'h000
`define OFS_CTRL_STATUS_A 12'h004
`define OFS_CTRL_STATUS_B 12'h008
`define OFS_CTRL_STATUS_C 12'h00C
`define OFS_BAUD_DIVISOR 12'h010
// ctrl_status_a fields
`define A_BUF_EMPTY 5
`define A_TX_DONE 6
`define A_DOUBLE 1
// ctrl_status_b fields
`define B_NINTH 0
`define B_RX_ON 4
`define B_TX_ON 3
`define B_SIZE2 2
// ctrl_status_c fields
`define C_SIZE_LO 1
`define C_STOP 3
`define C_PAR_LO 4
`define C_SYNC 6
`define C_SYNC_MASTER 7
// Baud divisor fields and size
`define BAUD_W 12
`define SIZE_NINE 3'h7
`define PAR_EVEN 2'h2
`define PAR_ODD 2'h3
`define DIV_NORMAL 5'h10
`define DIV_DOUBLE 5'h08
`define DIV_SYNC 5'h02
`define RESET_SIZE 3'h3
`endif

/* rtl/uart_tx_pkg.sv */
// Purpose: Types of the frame-format transmitter
// Assumes: Used as uart_tx_pkg::name only
// Notes: State codes are one-hot
package uart_tx_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_START = 5'h02,
		ST_DATA = 5'h04,
		ST_PARITY = 5'h08,
		ST_STOP = 5'h10
	} tx_state_t;
	typedef struct packed {
		logic [2:0] char_size_sel;
		logic [1:0] parity_mode_sel;
		logic stop_count_sel;
		logic transmit_on;
		logic receive_on;
		logic tx_ninth_bit;
		logic double_speed_sel;
		logic sync_mode_sel;
		logic sync_master;
		logic [11:0] baud_divisor;
	} cfg_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;
	typedef struct packed {
		cfg_t cfg;
		tx_state_t state;
		logic [8:0] buf_data;
		logic buf_full;
		logic [8:0] shift;
		logic [3:0] bit_cnt;
		logic stop2;
		logic par;
		logic [11:0] baud_cnt;
		logic [3:0] tick_cnt;
		logic tx_done_flag;
		logic serial_out;
		logic serial_oe;
		logic sync_clock_out;
		logic sync_clock_oe;
		logic xck_s1;
		logic xck_s2;
		logic xck_prev;
		apb_rsp_t rsp;
	} state_t;
endpackage : uart_tx_pkg

/* rtl/uart_frame_format_transmitter.sv */
// Purpose: Frame formatting and transmit path of a UART with APB registers
// Assumes: One clock core_clk; external sync clock sampled and edge detected
// Notes: Receiver logic is outside this block; its enable is only stored
// What this block does
// - Thirty frame formats are all accepted
// - Start bit, then data LSB first
// - Parity follows last data bit
// - Next frame back to back, else idle high
// - One format setting shared by both directions
// - Receiver checks only the first stop bit
// - Even parity is XOR; odd inverts it
// - Size field selects bits; 7 is nine
// - Parity field enables and picks even/odd
// - Stop select gives one or two stops
// - Transmit enable takes over serial output pin
// - Sync mode uses the sync clock pin
// - Data register write loads buffer, starts sending
// - Buffer moves when shifter idle or frame ends
// - Bit rate from divisor, speed, or sync clock
// - Unused high data bits are ignored
// - Ninth bit is sent unchanged
// - Bit clock is baud output over 16/8/2
// - Buffer empty flag tracks buffer contents
// - Done flag cleared by writing one
// - Parity on when upper field bit is one
`timescale 1ns/100ps
`include "uart_tx_regs.svh"
module uart_frame_format_transmitter (
	input wire logic core_clk,
	input wire logic rstn,
	input wire uart_tx_pkg::apb_req_t apb_req,
	output uart_tx_pkg::apb_rsp_t apb_rsp,
	output logic serial_out_pin,
	output logic serial_out_oe,
	input wire logic sync_clock_in,
	output logic sync_clock_out,
	output logic sync_clock_oe
);
	uart_tx_pkg::state_t s_ff;
	uart_tx_pkg::state_t nxt_s;

	// Data bits per frame from the size field
	function automatic logic [3:0] data_bits(input logic [2:0] sz);
		if (sz == `SIZE_NINE) begin
			data_bits = 4'h9;
		end else if (sz[2]) begin
			data_bits = 4'h8;
		end else begin
			data_bits = {2'h0, sz[1:0]} + 4'h5;
		end
	endfunction : data_bits

	// Parity over the valid data bits only
	function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n, input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < n) begin
				p = p ^ d[i];
			end
		end
		parity_of = p;
	endfunction : parity_of

	logic apb_wr;
	logic bit_tick;
	logic frame_end;
	logic [4:0] div_sel;
	logic [3:0] nbits;

	always_comb begin
		apb_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
		nbits = data_bits(s_ff.cfg.char_size_sel);
		if (s_ff.cfg.sync_mode_sel) begin
			div_sel = `DIV_SYNC;
		end else if (s_ff.cfg.double_speed_sel) begin
			div_sel = `DIV_DOUBLE;
		end else begin
			div_sel = `DIV_NORMAL;
		end
		frame_end = 1'b0;
		bit_tick = 1'b0;
		nxt_s = s_ff;
		nxt_s.xck_s1 = sync_clock_in;
		nxt_s.xck_s2 = s_ff.xck_s1;
		nxt_s.xck_prev = s_ff.xck_s2;

		// Baud generator: reload on zero, one bit tick per 16/8/2 reloads
		if (s_ff.baud_cnt == '0) begin
			nxt_s.baud_cnt = s_ff.cfg.baud_divisor;
			if (s_ff.tick_cnt == 4'(div_sel - 5'h01)) begin
				nxt_s.tick_cnt = '0;
				bit_tick = 1'b1;
			end else begin
				nxt_s.tick_cnt = s_ff.tick_cnt + 4'h1;
			end
		end else begin
			nxt_s.baud_cnt = s_ff.baud_cnt - 12'h001;
		end
		// Slave sync mode: data changes on falling edge of external clock
		if (s_ff.cfg.sync_mode_sel && !s_ff.cfg.sync_master) begin
			bit_tick = s_ff.xck_prev & ~s_ff.xck_s2;
		end
		if (s_ff.cfg.sync_mode_sel && s_ff.cfg.sync_master && s_ff.cfg.transmit_on) begin
			if (s_ff.baud_cnt == '0 && s_ff.tick_cnt == '0) begin
				nxt_s.sync_clock_out = 1'b0;
			end else if (s_ff.baud_cnt == '0 && s_ff.tick_cnt == 4'h1) begin
				nxt_s.sync_clock_out = 1'b1;
			end
			nxt_s.sync_clock_oe = 1'b1;
		end else begin
			nxt_s.sync_clock_oe = 1'b0;
			nxt_s.sync_clock_out = 1'b0;
		end

		// Shifter; one format set drives both directions, so a change mid-frame corrupts it
		if (bit_tick) begin
			unique case (s_ff.state)
				uart_tx_pkg::ST_IDLE: begin
					nxt_s.serial_out = 1'b1;
				end
				uart_tx_pkg::ST_START: begin
					nxt_s.serial_out = 1'b0;
					nxt_s.state = uart_tx_pkg::ST_DATA;
					nxt_s.bit_cnt = nbits;
				end
				uart_tx_pkg::ST_DATA: begin
					nxt_s.serial_out = s_ff.shift[0];
					nxt_s.shift = {1'b0, s_ff.shift[8:1]};
					nxt_s.bit_cnt = s_ff.bit_cnt - 4'h1;
					if (s_ff.bit_cnt == 4'h1) begin
						if (s_ff.cfg.parity_mode_sel[1]) begin
							nxt_s.state = uart_tx_pkg::ST_PARITY;
						end else begin
							nxt_s.state = uart_tx_pkg::ST_STOP;
						end
						nxt_s.stop2 = s_ff.cfg.stop_count_sel;
					end
				end
				uart_tx_pkg::ST_PARITY: begin
					nxt_s.serial_out = s_ff.par;
					nxt_s.state = uart_tx_pkg::ST_STOP;
				end
				uart_tx_pkg::ST_STOP: begin
					nxt_s.serial_out = 1'b1;
					// Second stop is sent but the far receiver only checks the first
					if (s_ff.stop2) begin
						nxt_s.stop2 = 1'b0;
					end else begin
						frame_end = 1'b1;
						nxt_s.state = uart_tx_pkg::ST_IDLE;
					end
				end
			endcase
		end

		// Load shifter when idle or on the tick that starts the last stop bit
		if (s_ff.buf_full && (s_ff.state == uart_tx_pkg::ST_IDLE || frame_end)) begin
			nxt_s.shift = s_ff.buf_data;
			nxt_s.par = parity_of(s_ff.buf_data, nbits, s_ff.cfg.parity_mode_sel[0]);
			nxt_s.buf_full = 1'b0;
			nxt_s.state = uart_tx_pkg::ST_START;
		end else if (frame_end) begin
			nxt_s.tx_done_flag = 1'b1;
		end

		// Pin released only once shifter and buffer are empty
		if (s_ff.cfg.transmit_on) begin
			nxt_s.serial_oe = 1'b1;
		end else if (s_ff.state == uart_tx_pkg::ST_IDLE && !s_ff.buf_full) begin
			nxt_s.serial_oe = 1'b0;
		end
		if (!nxt_s.serial_oe) begin
			nxt_s.serial_out = 1'b1;
		end

		// APB slave, zero wait states
		nxt_s.rsp.pready = 1'b0;
		nxt_s.rsp.pslverr = 1'b0;
		nxt_s.rsp.prdata = '0;
		if (apb_req.psel && !apb_req.penable) begin
			nxt_s.rsp.pready = 1'b1;
			unique case (apb_req.paddr)
				`OFS_DATA_BUFFER: begin
					// Transmit buffer is write-only; reads give zero
					nxt_s.rsp.prdata = '0;
				end
				`OFS_CTRL_STATUS_A: begin
					nxt_s.rsp.prdata[`A_BUF_EMPTY] = ~nxt_s.buf_full;
					nxt_s.rsp.prdata[`A_TX_DONE] = nxt_s.tx_done_flag;
					nxt_s.rsp.prdata[`A_DOUBLE] = s_ff.cfg.double_speed_sel;
				end
				`OFS_CTRL_STATUS_B: begin
					nxt_s.rsp.prdata[`B_NINTH] = s_ff.cfg.tx_ninth_bit;
					nxt_s.rsp.prdata[`B_SIZE2] = s_ff.cfg.char_size_sel[2];
					nxt_s.rsp.prdata[`B_TX_ON] = s_ff.cfg.transmit_on;
					nxt_s.rsp.prdata[`B_RX_ON] = s_ff.cfg.receive_on;
				end
				`OFS_CTRL_STATUS_C: begin
					nxt_s.rsp.prdata[`C_SIZE_LO +: 2] = s_ff.cfg.char_size_sel[1:0];
					nxt_s.rsp.prdata[`C_STOP] = s_ff.cfg.stop_count_sel;
					nxt_s.rsp.prdata[`C_PAR_LO +: 2] = s_ff.cfg.parity_mode_sel;
					nxt_s.rsp.prdata[`C_SYNC] = s_ff.cfg.sync_mode_sel;
					nxt_s.rsp.prdata[`C_SYNC_MASTER] = s_ff.cfg.sync_master;
				end
				`OFS_BAUD_DIVISOR: begin
					nxt_s.rsp.prdata[`BAUD_W-1:0] = s_ff.cfg.baud_divisor;
				end
				default: nxt_s.rsp.pslverr = 1'b1;
			endcase
		end
		if (apb_wr && s_ff.rsp.pready) begin
			unique case (apb_req.paddr)
				`OFS_DATA_BUFFER: begin
					// Full buffer write is dropped; software must poll empty first
					if (!s_ff.buf_full) begin
						nxt_s.buf_data = {s_ff.cfg.tx_ninth_bit, apb_req.pwdata[7:0]};
						nxt_s.buf_full = 1'b1;
					end
				end
				`OFS_CTRL_STATUS_A: begin
					// Set wins over the one-to-clear write
					if (apb_req.pwdata[`A_TX_DONE] && !(frame_end && !s_ff.buf_full)) begin
						nxt_s.tx_done_flag = 1'b0;
					end
					nxt_s.cfg.double_speed_sel = apb_req.pwdata[`A_DOUBLE];
				end
				`OFS_CTRL_STATUS_B: begin
					nxt_s.cfg.tx_ninth_bit = apb_req.pwdata[`B_NINTH];
					nxt_s.cfg.char_size_sel[2] = apb_req.pwdata[`B_SIZE2];
					nxt_s.cfg.transmit_on = apb_req.pwdata[`B_TX_ON];
					nxt_s.cfg.receive_on = apb_req.pwdata[`B_RX_ON];
				end
				`OFS_CTRL_STATUS_C: begin
					nxt_s.cfg.char_size_sel[1:0] = apb_req.pwdata[`C_SIZE_LO +: 2];
					nxt_s.cfg.stop_count_sel = apb_req.pwdata[`C_STOP];
					nxt_s.cfg.parity_mode_sel = apb_req.pwdata[`C_PAR_LO +: 2];
					nxt_s.cfg.sync_mode_sel = apb_req.pwdata[`C_SYNC];
					nxt_s.cfg.sync_master = apb_req.pwdata[`C_SYNC_MASTER];
				end
				`OFS_BAUD_DIVISOR: begin
					nxt_s.cfg.baud_divisor = apb_req.pwdata[`BAUD_W-1:0];
					nxt_s.baud_cnt = apb_req.pwdata[`BAUD_W-1:0];
				end
				default: ;
			endcase
		end
		if (apb_req.psel && apb_req.penable) begin
			nxt_s.rsp.pready = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_ff.cfg.char_size_sel <= `RESET_SIZE;
			s_ff.cfg.parity_mode_sel <= 2'h0;
			s_ff.cfg.stop_count_sel <= 1'b0;
			s_ff.cfg.transmit_on <= 1'b0;
			s_ff.cfg.receive_on <= 1'b0;
			s_ff.cfg.tx_ninth_bit <= 1'b0;
			s_ff.cfg.double_speed_sel <= 1'b0;
			s_ff.cfg.sync_mode_sel <= 1'b0;
			s_ff.cfg.sync_master <= 1'b0;
			s_ff.cfg.baud_divisor <= 12'h000;
			s_ff.state <= uart_tx_pkg::ST_IDLE;
			s_ff.buf_data <= 9'h000;
			s_ff.buf_full <= 1'b0;
			s_ff.shift <= 9'h000;
			s_ff.bit_cnt <= 4'h0;
			s_ff.stop2 <= 1'b0;
			s_ff.par <= 1'b0;
			s_ff.baud_cnt <= 12'h000;
			s_ff.tick_cnt <= 4'h0;
			s_ff.tx_done_flag <= 1'b0;
			// Line idles high from reset
			s_ff.serial_out <= 1'b1;
			s_ff.serial_oe <= 1'b0;
			s_ff.sync_clock_out <= 1'b0;
			s_ff.sync_clock_oe <= 1'b0;
			s_ff.xck_s1 <= 1'b0;
			s_ff.xck_s2 <= 1'b0;
			s_ff.xck_prev <= 1'b0;
			s_ff.rsp <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign apb_rsp = s_ff.rsp;
	assign serial_out_pin = s_ff.serial_out;
	assign serial_out_oe = s_ff.serial_oe;
	assign sync_clock_out = s_ff.sync_clock_out;
	assign sync_clock_oe = s_ff.sync_clock_oe;
endmodule : uart_frame_format_transmitter

/* sim/uart_rx_model.sv */
// Purpose: Far-end serial receiver on the transmit line
// Assumes: Bench gives bit time in core_clk cycles and the format
// Notes: Samples mid-bit, so a late first bit is tolerated
`timescale 1ns/100ps
module uart_rx_model (
	input wire logic core_clk,
	input wire logic line,
	input wire logic [4:0] bit_len,
	input wire logic [3:0] nbits,
	input wire logic par_on,
	input wire logic two_stop,
	output logic [8:0] rx_data,
	output logic rx_par,
	output logic [1:0] rx_stop,
	output logic [7:0] frames
);
	initial begin
		frames = 8'h00;
		forever begin
			@(negedge line);
			repeat (bit_len / 2) @(posedge core_clk);
			if (line === 1'b0) begin
				rx_data = 9'h000;
				rx_stop = 2'h0;
				for (int i = 0; i < nbits; i++) begin
					repeat (bit_len) @(posedge core_clk);
					rx_data[i] = line;
				end
				if (par_on) begin
					repeat (bit_len) @(posedge core_clk);
					rx_par = line;
				end
				// Only the first stop would flag a frame error
				for (int i = 0; i <= int'(two_stop); i++) begin
					repeat (bit_len) @(posedge core_clk);
					rx_stop[i] = line;
				end
				frames = frames + 8'h01;
			end
		end
	end
endmodule : uart_rx_model

/* sim/uart_tx_checker.sv */
// Purpose: Port checks of the frame transmitter
// Assumes: One clock domain
// Notes: Any bit lasts two clocks or more
`timescale 1ns/100ps
module uart_tx_checker (
	input wire logic core_clk,
	input wire logic rstn,
	input wire uart_tx_pkg::apb_req_t apb_req,
	input wire uart_tx_pkg::apb_rsp_t apb_rsp,
	input wire logic serial_out_pin,
	input wire logic serial_out_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	a_setup_gets_ready: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
		else $error("no pready");
	a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready held");
	a_no_stray_ready: assert property (!apb_req.psel |=> !apb_rsp.pready)
		else $error("stray pready");
	a_err_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("lone pslverr");
	a_idle_high: assert property (!serial_out_oe |-> serial_out_pin)
		else $error("idle line low");
	a_start_driven: assert property ($fell(serial_out_pin) |-> serial_out_oe)
		else $error("undriven start");
	a_low_bit_len: assert property ($fell(serial_out_pin) |=> !serial_out_pin)
		else $error("short low bit");
	a_high_bit_len: assert property ($rose(serial_out_pin) |=> serial_out_pin)
		else $error("short high bit");
	c_frame: cover property ($fell(serial_out_pin));
	c_err: cover property (apb_rsp.pslverr);
	c_write: cover property (apb_rsp.pready && apb_req.pwrite);
endmodule : uart_tx_checker
bind uart_frame_format_transmitter uart_tx_checker chk (.core_clk, .rstn, .apb_req, .apb_rsp, .serial_out_pin,
	.serial_out_oe);

/* sim/uart_frame_format_transmitter_tb.sv */
// Purpose: Self-checking bench of the frame transmitter
// Assumes: Divisor 0, a bit is 16 clocks, 8 at double speed
// Notes: Sync modes untested; sync_clock_in held low
`timescale 1ns/100ps
`include "uart_tx_regs.svh"
module uart_frame_format_transmitter_tb;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	uart_tx_pkg::apb_req_t req = '0;
	uart_tx_pkg::apb_rsp_t rsp;
	logic pin, oe, rxp, serr;
	logic pon = 1'b0;
	logic two = 1'b0;
	logic [4:0] blen = 5'h10;
	logic [3:0] nb = 4'h8;
	logic [8:0] rxd;
	logic [1:0] rxs;
	logic [7:0] frames;
	logic [31:0] rd;
	int err_total = 0;
	int checked = 0;
	uart_frame_format_transmitter dut (.core_clk, .rstn, .apb_req(req), .apb_rsp(rsp), .serial_out_pin(pin),
		.serial_out_oe(oe), .sync_clock_in(1'b0), .sync_clock_out(), .sync_clock_oe());
	uart_rx_model far (.core_clk, .line(pin), .bit_len(blen), .nbits(nb), .par_on(pon), .two_stop(two),
		.rx_data(rxd), .rx_par(rxp), .rx_stop(rxs), .frames);
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge core_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 9);
		rd = rsp.prdata;
		serr = rsp.pslverr;
		req <= '0;
		if (rsp.pready !== 1'b1) begin
			chk(32'h0, 32'h1);
			tally_and_finish();
		end
	endtask : apb
	task automatic wait_frames(input logic [7:0] target);
		int n;
		n = 0;
		while (frames !== target && n < 2000) begin
			@(posedge core_clk);
			n++;
		end
		chk(32'(frames), 32'(target));
		if (frames !== target) tally_and_finish();
	endtask : wait_frames
	task automatic wait_flag(input int b);
		int n;
		n = 0;
		do begin
			apb(1'b0, `OFS_CTRL_STATUS_A, 32'h0);
			n++;
		end while (rd[b] !== 1'b1 && n < 100);
		chk(32'(rd[b]), 32'h1);
		if (rd[b] !== 1'b1) tally_and_finish();
	endtask : wait_flag
	task automatic setfmt(input logic [2:0] sz, input logic [1:0] pm, input logic st, input logic ninth);
		apb(1'b1, `OFS_CTRL_STATUS_C, {26'h0, pm, st, sz[1:0], 1'b0});
		apb(1'b1, `OFS_CTRL_STATUS_B, {28'h0, 1'b1, sz[2], 1'b0, ninth});
		nb <= (sz == 3'h7) ? 4'h9 : 4'h5 + 4'(sz);
		pon <= pm[1];
		two <= st;
	endtask : setfmt
	task automatic send(input logic [2:0] sz, input logic [1:0] pm, input logic st, input logic [8:0] d);
		logic [8:0] m;
		logic [7:0] f;
		apb(1'b1, `OFS_CTRL_STATUS_A, 32'h40);
		setfmt(sz, pm, st, d[8]);
		f = frames;
		apb(1'b1, `OFS_DATA_BUFFER, {24'h0, d[7:0]});
		m = d & ((9'h001 << nb) - 9'h001);
		wait_frames(f + 8'h01);
		chk(32'(rxd), 32'(m));
		if (pm[1]) chk(32'(rxp), 32'(^m ^ pm[0]));
		chk(32'(rxs), {30'h0, st, 1'b1});
		// Format may only change once the line is quiet
		wait_flag(6);
	endtask : send
	task automatic t_regs;
		apb(1'b0, `OFS_CTRL_STATUS_C, 32'h0);
		chk(rd & 32'h0000_00FE, 32'h0000_0006);
		apb(1'b0, `OFS_CTRL_STATUS_A, 32'h0);
		chk(rd & 32'h0000_0062, 32'h0000_0020);
		apb(1'b1, 12'h020, 32'hFFFF_FFFF);
		chk(32'(serr), 32'h1);
		apb(1'b0, `OFS_CTRL_STATUS_A, 32'h0);
		chk(32'(serr), 32'h0);
	endtask : t_regs
	task automatic t_formats;
		logic [2:0] sz;
		for (int i = 0; i < 40; i++) begin
			sz = (i % 5 == 4) ? 3'h7 : 3'(i % 5);
			send(sz, 2'(i / 10), 1'((i / 5) % 2), 9'(i * 77 + 165));
		end
	endtask : t_formats
	task automatic t_back2back;
		logic [7:0] f;
		int n;
		apb(1'b1, `OFS_CTRL_STATUS_A, 32'h42);
		blen <= 5'h08;
		setfmt(3'h3, 2'h0, 1'b0, 1'b0);
		f = frames;
		apb(1'b1, `OFS_DATA_BUFFER, 32'h3C);
		wait_flag(5);
		apb(1'b1, `OFS_DATA_BUFFER, 32'hC3);
		apb(1'b0, `OFS_CTRL_STATUS_A, 32'h0);
		chk(rd & 32'h0000_0060, 32'h0);
		wait_frames(f + 8'h01);
		chk(32'(rxd), 32'h3C);
		n = 0;
		while (pin !== 1'b0 && n < 20) begin
			@(posedge core_clk);
			n++;
		end
		chk(32'(n < 8), 32'h1);
		wait_frames(f + 8'h02);
		chk(32'(rxd), 32'hC3);
		wait_flag(6);
		apb(1'b1, `OFS_CTRL_STATUS_A, 32'h42);
		apb(1'b0, `OFS_CTRL_STATUS_A, 32'h0);
		chk(rd & 32'h0000_0060, 32'h20);
	endtask : t_back2back
	initial begin
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		t_regs();
		t_formats();
		t_back2back();
		tally_and_finish();
	end
endmodule : uart_frame_format_transmitter_tb
